// ---- rtl/sac_adc_ctrl.sv ----
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
module sac_adc_ctrl
    import sac_pkg::*;
#(
    parameter int RES_W = 10
)(
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic cmp_i,
    input wire logic rc_clk_i,
    input wire logic sleep_i,
    output logic [RES_W-1:0] dac_o,
    output logic hold_o,
    output logic [2:0] channel_o,
    output logic ref_ext_o,
    output logic [3:0] analog_pin_select_o,
    output logic irq_o,
    output logic wake_o,
    output logic isr_vector_o
);

    // ==========================================================
    // helpers
    function automatic logic [5:0] div_last(input logic [2:0] sel);
        case (sel)
            CS_DIV2: div_last = 6'h01;
            CS_DIV4: div_last = 6'h03;
            CS_DIV8: div_last = 6'h07;
            CS_DIV16: div_last = 6'h0f;
            CS_DIV32: div_last = 6'h1f;
            default: div_last = 6'h3f;
        endcase
    endfunction

    function automatic logic [7:0] fmt_res(input logic [RES_W-1:0] r, input logic just, input logic hi);
        if (just)
            fmt_res = hi ? {6'h00, r[9:8]} : r[7:0];
        else
            fmt_res = hi ? r[9:2] : {r[1:0], 6'h00};
    endfunction

    // ==========================================================
    // registers
    sac_ctrl_t ctrl_q;
    logic [7:0] pin_clk_q;
    logic gie_q;
    logic irq_en_q;
    logic flag_q;
    logic [RES_W-1:0] result_q;
    logic [7:0] rdata_q;
    sac_state_t state_q;
    logic [RES_W-1:0] sar_q;
    logic [3:0] bit_idx_q;
    logic [1:0] abort_cnt_q;
    logic [5:0] div_cnt_q;
    logic [2:0] cmp_sync_q;
    logic cmp_lvl_q;
    logic [2:0] rc_sync_q;
    logic rc_lvl_q;
    logic [3:0] tad_cnt_q;

    logic [2:0] clk_sel;
    logic rc_sel;
    logic busy;
    logic tick;
    logic rc_rise;
    logic done_ev;
    logic sw_abort;
    logic kill;
    logic wr_ctrl;
    logic wr_clk;

    assign clk_sel = pin_clk_q[CLK_SEL_LSB +: 3];
    assign rc_sel = (clk_sel[1:0] == CS_RC_LOW);
    assign busy = (state_q == ST_SAMPLE) || (state_q == ST_CONV);
    assign wr_ctrl = wr_i && (addr_i == OFS_CTRL);
    assign wr_clk = wr_i && (addr_i == OFS_PIN_CLK);
    // last bit resolved
    // abort or kill in the last cycle wins, so the old result survives
    assign done_ev = (state_q == ST_CONV) && tick && (bit_idx_q == 4'h0) && !kill && !sw_abort;
    assign sw_abort = busy && wr_ctrl && !wdata_i[1];
    // rc clock cannot keep a divided-clock conversion alive through sleep
    assign kill = !ctrl_q.on || (sleep_i && !rc_sel);

    // ==========================================================
    // input synchronisers: a change counts once stages 2 and 3 agree
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            cmp_sync_q <= 3'h0;
            cmp_lvl_q <= 1'b0;
            rc_sync_q <= 3'h0;
            rc_lvl_q <= 1'b0;
        end
        else
        begin
            cmp_sync_q <= {cmp_sync_q[1:0], cmp_i};
            rc_sync_q <= {rc_sync_q[1:0], rc_clk_i};
            if (cmp_sync_q[1] == cmp_sync_q[2])
                cmp_lvl_q <= cmp_sync_q[2];
            if (rc_sync_q[1] == rc_sync_q[2])
                rc_lvl_q <= rc_sync_q[2];
        end
    end

    assign rc_rise = (rc_sync_q[1] == rc_sync_q[2]) && rc_sync_q[2] && !rc_lvl_q;

    // ==========================================================
    // bit period generator
    // divided ticks or RC edges
    // divided ticks count system clocks only
    assign tick = rc_sel ? rc_rise : (div_cnt_q == div_last(clk_sel));

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            div_cnt_q <= 6'h00;
        else if (wr_clk || tick || rc_sel)
            div_cnt_q <= 6'h00;
        else
            div_cnt_q <= div_cnt_q + 6'h01;
    end

    // ==========================================================
    // control and configuration registers
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            ctrl_q <= sac_ctrl_t'(CTRL_RST);
        else
        begin
            if (wr_ctrl)
                ctrl_q <= sac_ctrl_t'(wdata_i);
            ctrl_q.unused <= 1'b0;
            // hardware clear of convert_go wins over the write
            if (done_ev || kill)
                ctrl_q.go <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pin_clk_q <= PIN_CLK_RST;
            gie_q <= 1'b0;
            irq_en_q <= 1'b0;
        end
        else
        begin
            if (wr_clk)
                pin_clk_q <= {1'b0, wdata_i[6:0]};
            if (wr_i && (addr_i == OFS_INT_CTRL))
                gie_q <= wdata_i[GIE_BIT];
            if (wr_i && (addr_i == OFS_PIE))
                irq_en_q <= wdata_i[DONE_BIT];
        end
    end

    // flag sets at every completion; set wins over a clearing write
    // only a software write ever clears it
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            flag_q <= 1'b0;
        else if (done_ev)
            flag_q <= 1'b1;
        else if (wr_i && (addr_i == OFS_PIR))
            flag_q <= wdata_i[DONE_BIT];
    end

    // result pair loads only at completion
    // no bus path into the result
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            result_q <= '0;
        else if (done_ev)
            result_q <= {sar_q[RES_W-1:1], cmp_lvl_q};
    end

    // ==========================================================
    // conversion sequencer
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_q <= ST_IDLE;
            sar_q <= '0;
            bit_idx_q <= MSB_IDX;
            abort_cnt_q <= 2'h0;
        end
        else if (kill)
            state_q <= ST_IDLE;
        else if (sw_abort)
        begin
            // keep result, hold off two bit periods
            state_q <= ST_ABORT;
            abort_cnt_q <= 2'h0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (ctrl_q.go)
                        state_q <= ST_SAMPLE;
                ST_SAMPLE:
                    // one period of sampling hand-off, then MSB trial
                    if (tick)
                    begin
                        state_q <= ST_CONV;
                        sar_q <= {1'b1, {(RES_W-1){1'b0}}};
                        bit_idx_q <= MSB_IDX;
                    end
                ST_CONV:
                    if (tick)
                    begin
                        // keep or drop trial bit, try next lower
                        sar_q[bit_idx_q] <= cmp_lvl_q;
                        if (bit_idx_q == 4'h0)
                            state_q <= ST_IDLE;
                        else
                        begin
                            sar_q[bit_idx_q - 4'h1] <= 1'b1;
                            bit_idx_q <= bit_idx_q - 4'h1;
                        end
                    end
                ST_ABORT:
                    if (tick)
                    begin
                        abort_cnt_q <= abort_cnt_q + 2'h1;
                        if (abort_cnt_q == ABORT_TADS - 2'h1)
                            state_q <= ST_IDLE;
                    end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // read port: data one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            rdata_q <= 8'h00;
        else if (!rd_i)
            rdata_q <= 8'h00;
        else
        begin
            case (addr_i)
                OFS_CTRL: rdata_q <= ctrl_q;
                OFS_PIN_CLK: rdata_q <= pin_clk_q;
                OFS_INT_CTRL: rdata_q <= {gie_q, 7'h00};
                OFS_PIE: rdata_q <= {1'b0, irq_en_q, 6'h00};
                OFS_PIR: rdata_q <= {1'b0, flag_q, 6'h00};
                OFS_RES_HI: rdata_q <= fmt_res(result_q, ctrl_q.justify, 1'b1);
                OFS_RES_LO: rdata_q <= fmt_res(result_q, ctrl_q.justify, 1'b0);
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // outputs
    assign rdata_o = rdata_q;
    assign dac_o = sar_q;
    assign hold_o = (state_q == ST_CONV);
    assign channel_o = ctrl_q.chan;
    // negative reference is ground in the analog section
    assign ref_ext_o = ctrl_q.ref_ext;
    assign analog_pin_select_o = pin_clk_q[3:0];
    assign irq_o = flag_q && irq_en_q;
    // wake while asleep; the core completes its next instruction first
    assign wake_o = sleep_i && irq_o;
    assign isr_vector_o = irq_o && gie_q;

    // ==========================================================
    // checks
    always_ff @(posedge ref_clk_i or posedge reset_i)
    begin
        if (reset_i)
            tad_cnt_q <= 4'h0;
        else if (state_q == ST_IDLE)
            tad_cnt_q <= 4'h0;
        else if (busy && tick)
            tad_cnt_q <= tad_cnt_q + 4'h1;
    end

    property p_done_go;
        @(posedge ref_clk_i) disable iff (reset_i) done_ev && !kill |=> !ctrl_q.go && flag_q;
    endproperty
    a_done_go: assert property (p_done_go) else $error("go not cleared or flag not set at end");

    property p_tad_count;
        @(posedge ref_clk_i) disable iff (reset_i) done_ev |-> tad_cnt_q == TAD_PER_CONV - 4'h1;
    endproperty
    a_tad_count: assert property (p_tad_count) else $error("conversion not eleven bit periods");

    property p_abort_keep;
        @(posedge ref_clk_i) disable iff (reset_i) sw_abort && !kill |=> state_q == ST_ABORT && $stable(result_q);
    endproperty
    a_abort_keep: assert property (p_abort_keep) else $error("abort changed result or state");

    property p_ro_result;
        @(posedge ref_clk_i) disable iff (reset_i)
            wr_i && (addr_i == OFS_RES_HI || addr_i == OFS_RES_LO) && !done_ev |=> $stable(result_q);
    endproperty
    a_ro_result: assert property (p_ro_result) else $error("result changed by write");

    property p_flag_hold;
        @(posedge ref_clk_i) disable iff (reset_i) flag_q && !(wr_i && addr_i == OFS_PIR) |=> flag_q;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by hardware");

    property p_flag_irq;
        @(posedge ref_clk_i) disable iff (reset_i) done_ev && irq_en_q && !wr_i |=> irq_o ##0 flag_q;
    endproperty
    a_flag_irq: assert property (p_flag_irq) else $error("no request after enabled completion");

    property p_div2;
        @(posedge ref_clk_i) disable iff (reset_i)
            tick && clk_sel == CS_DIV2 && !wr_clk |=> !tick ##1 (tick || $past(wr_clk));
    endproperty
    a_div2: assert property (p_div2) else $error("divide by two spacing wrong");

    property p_div_restart;
        @(posedge ref_clk_i) disable iff (reset_i) wr_clk |=> div_cnt_q == 6'h00;
    endproperty
    a_div_restart: assert property (p_div_restart) else $error("divider not restarted");

    property p_res_fmt;
        @(posedge ref_clk_i) disable iff (reset_i)
            rd_i && addr_i == OFS_RES_HI && ctrl_q.justify |=> rdata_o[7:2] == 6'h00;
    endproperty
    a_res_fmt: assert property (p_res_fmt) else $error("right justified high byte not padded");

    property p_wake_vec;
        @(posedge ref_clk_i) disable iff (reset_i) sleep_i && irq_o && !gie_q |-> wake_o && !isr_vector_o;
    endproperty
    a_wake_vec: assert property (p_wake_vec) else $error("wake or vector wrong");

    c_done: cover property (@(posedge ref_clk_i) disable iff (reset_i) done_ev);
    c_abort: cover property (@(posedge ref_clk_i) disable iff (reset_i) sw_abort);
    c_wake: cover property (@(posedge ref_clk_i) disable iff (reset_i) wake_o);
    c_rc_done: cover property (@(posedge ref_clk_i) disable iff (reset_i) done_ev && rc_sel);

endmodule // sac_adc_ctrl

// ---- rtl/sac_pkg.sv ----
// ==========================================================
// converter control constants
package sac_pkg;
    // register offsets on the plain port
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFS_CTRL = 3'h0;
    localparam logic [2:0] OFS_PIN_CLK = 3'h1;
    localparam logic [2:0] OFS_INT_CTRL = 3'h2;
    localparam logic [2:0] OFS_PIE = 3'h3;
    localparam logic [2:0] OFS_PIR = 3'h4;
    localparam logic [2:0] OFS_RES_HI = 3'h5;
    localparam logic [2:0] OFS_RES_LO = 3'h6;

    // field positions
    localparam int CLK_SEL_LSB = 4;
    localparam int GIE_BIT = 7;
    localparam int DONE_BIT = 6;
    localparam int JUST_PAD = 6;

    // reset values
    localparam logic [7:0] PIN_CLK_RST = 8'h0f;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // conversion clock selections
    localparam logic [2:0] CS_DIV2 = 3'h0;
    localparam logic [2:0] CS_DIV4 = 3'h4;
    localparam logic [2:0] CS_DIV8 = 3'h1;
    localparam logic [2:0] CS_DIV16 = 3'h5;
    localparam logic [2:0] CS_DIV32 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h6;
    localparam logic [1:0] CS_RC_LOW = 2'h3;

    // sequence lengths in bit periods, and the MSB bit index
    localparam logic [3:0] TAD_PER_CONV = 4'hb;
    localparam logic [1:0] ABORT_TADS = 2'h2;
    localparam logic [3:0] MSB_IDX = 4'h9;

    typedef struct packed {
        logic justify;
        logic ref_ext;
        logic unused;
        logic [2:0] chan;
        logic go;
        logic on;
    } sac_ctrl_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONV = 2'b11,
        ST_ABORT = 2'b10
    } sac_state_t;
endpackage

// ---- verif/test_sac_adc_ctrl.sv ----
`timescale 1ns/10ps
module test_sac_adc_ctrl
    import sac_pkg::*;
;
    // ==========================================================
    // stimulus signals
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic cmp_i = 1'b0;
    logic rc_clk_i = 1'b0;
    logic sleep_i = 1'b0;
    logic [7:0] rdata_o;
    logic [9:0] dac_o;
    logic hold_o;
    logic [2:0] channel_o;
    logic ref_ext_o;
    logic [3:0] analog_pin_select_o;
    logic irq_o;
    logic wake_o;
    logic isr_vector_o;
    logic [9:0] vin = 10'h000;
    int seed = 81;
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;

    always #5 ref_clk_i = ~ref_clk_i;
    // odd half period keeps the rc edges off the system clock grid
    always #85.3 rc_clk_i = ~rc_clk_i;
    // ideal comparator against the trial code
    always @(posedge ref_clk_i) cmp_i <= (vin >= dac_o);

    sac_adc_ctrl dut_u (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .cmp_i(cmp_i),
        .rc_clk_i(rc_clk_i),
        .sleep_i(sleep_i),
        .dac_o(dac_o),
        .hold_o(hold_o),
        .channel_o(channel_o),
        .ref_ext_o(ref_ext_o),
        .analog_pin_select_o(analog_pin_select_o),
        .irq_o(irq_o),
        .wake_o(wake_o),
        .isr_vector_o(isr_vector_o)
    );

    // ==========================================================
    // helpers
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge ref_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fails = fails + 1;
            summarize();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(16'(d), 16'(exp));
    endtask

    // expected pair {high, low} for a result and justification
    function automatic logic [15:0] fmt(input logic [9:0] v, input logic j);
        if (j)
            return {6'h00, v};
        return {v, 6'h00};
    endfunction

    // bit period in system cycles; rc is about 17 cycles
    function automatic int bit_period(input logic [2:0] s);
        if (s[1:0] == CS_RC_LOW)
            return 17;
        return 2 << (int'(s[2]) + 2 * int'(s[1:0]));
    endfunction

    // ==========================================================
    // main sequence
    initial
    begin
        logic [7:0] d;
        logic [7:0] c;
        logic [2:0] ch;
        logic [15:0] e;
        logic [9:0] last;
        int n;
        int t0;
        repeat (4) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        #1;
        chk(16'(analog_pin_select_o), 16'h000f);
        chk(16'(channel_o), 16'h0000);
        rchk(OFS_CTRL, CTRL_RST);
        rchk(OFS_PIN_CLK, PIN_CLK_RST);
        rchk(OFS_PIE, 8'h00);
        rchk(OFS_PIR, 8'h00);
        rchk(OFS_INT_CTRL, 8'h00);
        rchk(3'h7, 8'h00);
        @(posedge ref_clk_i);
        #1;
        chk(16'(rdata_o), 16'h0000);
        $display("test reset done");
        last = 10'h000;
        for (int i = 0; i < 8; i++)
        begin
            n = bit_period(i[2:0]);
            vin <= (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : 10'($random(seed));
            ch = 3'($random(seed) & 3);
            d = 8'($random(seed));
            // pins routed to analog before use
            wr(OFS_PIN_CLK, {1'b0, i[2:0], d[3:0]});
            chk(16'(analog_pin_select_o), 16'(d[3:0]));
            wr(OFS_PIE, 8'(i[1]) << DONE_BIT);
            wr(OFS_INT_CTRL, 8'(i[2]) << GIE_BIT);
            c = {i[0], i[2] ^ i[1], 1'b0, ch, 1'b0, 1'b1};
            wr(OFS_CTRL, c);
            chk(16'(channel_o), 16'(ch));
            chk(16'(ref_ext_o), 16'(c[6]));
            repeat (8) @(posedge ref_clk_i);
            wr(OFS_CTRL, c | 8'h02);
            t0 = cyc;
            sleep_i <= (i[1:0] == CS_RC_LOW);
            d = 8'h00;
            while (d[DONE_BIT] !== 1'b1 && cyc - t0 < 2000)
                rd(OFS_PIR, d);
            chk(16'(cyc - t0 >= 10 * n - 4 && cyc - t0 <= 11 * n + 8), 16'h0001);
            chk(16'(irq_o), 16'(i[1]));
            chk(16'(wake_o), 16'(i[1] && i[1:0] == CS_RC_LOW));
            chk(16'(isr_vector_o), 16'(i[1] & i[2]));
            rchk(OFS_CTRL, c);
            // the fast selections outrun the comparator sync, result not judged
            if (n >= 8)
            begin
                e = fmt(vin, c[7]);
                rchk(OFS_RES_HI, e[15:8]);
                rchk(OFS_RES_LO, e[7:0]);
                wr(OFS_CTRL, c ^ 8'h80);
                e = fmt(vin, ~c[7]);
                rchk(OFS_RES_HI, e[15:8]);
                wr(OFS_RES_HI, 8'hff);
                wr(OFS_RES_LO, 8'h55);
                rchk(OFS_RES_LO, e[7:0]);
                last = vin;
            end
            repeat (20) @(posedge ref_clk_i);
            rchk(OFS_PIR, 8'h40);
            wr(OFS_PIR, 8'h00);
            chk(16'(irq_o), 16'h0000);
            sleep_i <= 1'b0;
        end
        $display("test conversions done");
        e = fmt(last, 1'b1);
        vin <= ~last;
        wr(OFS_PIN_CLK, {1'b0, CS_DIV64, 4'h3});
        wr(OFS_CTRL, 8'h83);
        repeat (200) @(posedge ref_clk_i);
        #1;
        chk(16'(hold_o), 16'h0001);
        wr(OFS_CTRL, 8'h81);
        repeat (200) @(posedge ref_clk_i);
        #1;
        chk(16'(hold_o), 16'h0000);
        rchk(OFS_PIR, 8'h00);
        rchk(OFS_RES_HI, e[15:8]);
        rchk(OFS_RES_LO, e[7:0]);
        $display("test abort done");
        // sleep on a system-derived clock kills the conversion
        wr(OFS_PIN_CLK, {1'b0, CS_DIV16, 4'h3});
        wr(OFS_CTRL, 8'h83);
        repeat (40) @(posedge ref_clk_i);
        sleep_i <= 1'b1;
        repeat (300) @(posedge ref_clk_i);
        rchk(OFS_CTRL, 8'h81);
        rchk(OFS_PIR, 8'h00);
        rchk(OFS_RES_LO, e[7:0]);
        sleep_i <= 1'b0;
        $display("test sleep done");
        summarize();
    end
endmodule // test_sac_adc_ctrl
